// >>> hdl/arc_pkg.sv
package arc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_DATA_RATE  = 6'h04;
  localparam logic [5:0] IDX_REF_CTRL   = 6'h05;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h06;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h07;
  localparam logic [5:0] IDX_MONITOR    = 6'h08;

  // Data rate control fields.
  localparam int unsigned DR_RATE_LSB   = 0;
  localparam int unsigned DR_RATE_W     = 4;
  localparam int unsigned DR_FILTER_BIT = 4;
  localparam int unsigned DR_CLK_BIT    = 6;
  localparam logic [7:0]  DATA_RATE_RST = 8'h14;
  localparam logic [7:0]  DATA_RATE_WM  = 8'h5f;

  // Reference control fields.
  localparam int unsigned RC_PWR_LSB    = 0;
  localparam int unsigned RC_SEL_LSB    = 2;
  localparam int unsigned RC_NBUF_BIT   = 4;
  localparam int unsigned RC_PBUF_BIT   = 5;
  localparam logic [7:0]  REF_CTRL_RST  = 8'h00;
  localparam logic [7:0]  REF_CTRL_WM   = 8'h3f;

  // Reference source select and internal reference power codes.
  localparam logic [1:0] REFSEL_EXT0 = 2'h0;
  localparam logic [1:0] REFSEL_EXT1 = 2'h1;
  localparam logic [1:0] REFSEL_INT  = 2'h2;
  localparam logic [1:0] REFPWR_OFF  = 2'h0;
  localparam logic [1:0] REFPWR_AUTO = 2'h1;
  localparam logic [1:0] REFPWR_ON   = 2'h2;

  // Interrupt status bits.
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_CONV     = 0;
  localparam int unsigned IRQ_REFL0    = 1;
  localparam int unsigned IRQ_REFL1    = 2;
  localparam logic [2:0]  IRQ_RST      = 3'h0;

  // Monitor register bits.
  localparam int unsigned MON_FLAG_LSB = 0;
  localparam int unsigned MON_REFON    = 2;
  localparam int unsigned MON_EXTCLK   = 3;
  localparam int unsigned MON_BUSY     = 4;

  // Modulator clock is the system clock divided by sixteen.
  localparam logic [3:0]  MOD_DIV_LAST = 4'hf;
  localparam int unsigned OSR_W        = 17;

  typedef enum logic [1:0] {ARC_REF_EXT0, ARC_REF_EXT1, ARC_REF_INT} arc_ref_src_t;
  typedef enum logic {ARC_IDLE, ARC_RUN} arc_conv_state_t;

  typedef struct packed {
    arc_ref_src_t src;
    logic         int_ref_on;
    logic         pos_buf_en;
    logic         neg_buf_en;
  } arc_ref_cfg_t;

  typedef struct packed {
    logic              ext_clk_sel;
    logic              low_latency;
    logic [OSR_W-1:0]  osr;
  } arc_rate_cfg_t;

  function automatic arc_ref_src_t arc_ref_decode(input logic [1:0] sel);
    unique case (sel)
      REFSEL_EXT1: arc_ref_decode = ARC_REF_EXT1;
      REFSEL_INT:  arc_ref_decode = ARC_REF_INT;
      default:     arc_ref_decode = ARC_REF_EXT0;
    endcase
  endfunction : arc_ref_decode

  // Undefined codes run at the fastest defined ratio.
  function automatic logic [OSR_W-1:0] arc_osr_decode(input logic [3:0] code);
    unique case (code)
      4'h0:    arc_osr_decode = 17'h19000;
      4'h1:    arc_osr_decode = 17'h0c800;
      4'h2:    arc_osr_decode = 17'h06400;
      4'h3:    arc_osr_decode = 17'h03c00;
      4'h4:    arc_osr_decode = 17'h03200;
      4'h5:    arc_osr_decode = 17'h01400;
      4'h6:    arc_osr_decode = 17'h010a8;
      4'h7:    arc_osr_decode = 17'h00a00;
      4'h8:    arc_osr_decode = 17'h00500;
      4'h9:    arc_osr_decode = 17'h00280;
      4'ha:    arc_osr_decode = 17'h00140;
      4'hb:    arc_osr_decode = 17'h00100;
      4'hc:    arc_osr_decode = 17'h00080;
      default: arc_osr_decode = 17'h00040;
    endcase
  endfunction : arc_osr_decode

endpackage : arc_pkg

// >>> hdl/arc_conv_timer.sv
`timescale 1ns/10ps
module arc_conv_timer
  import arc_pkg::*;
(
  // System
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [OSR_W-1:0] osr_i,
  // Timing
  output logic                  busy_o,
  output logic                  mod_tick_o,
  output logic                  done_o
);

  arc_conv_state_t   state_r;
  logic [3:0]        div_r;
  logic [OSR_W-1:0]  cnt_r;
  logic [OSR_W-1:0]  osr_r;
  logic [OSR_W-1:0]  osr_last;
  logic [20:0]       cyc_r;

  assign busy_o     = (state_r == ARC_RUN);
  assign mod_tick_o = busy_o && (div_r == MOD_DIV_LAST);
  assign osr_last   = OSR_W'(osr_r - 17'h00001);
  assign done_o     = mod_tick_o && (cnt_r == osr_last);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ARC_IDLE;
    end else begin
      unique case (state_r)
        ARC_IDLE: if (run_i) state_r <= ARC_RUN;
        ARC_RUN:  if (!run_i) state_r <= ARC_IDLE;
      endcase
    end
  end

  // Modulator clock divider.
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      div_r <= 4'h0;
    end else begin
      div_r <= 4'(div_r + 4'h1);
    end
  end

  // The ratio is taken at each conversion start and depends on the rate code only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osr_r <= arc_osr_decode(4'h0);
    end else if (!busy_o || done_o) begin
      osr_r <= osr_i;
    end
  end

  // A result is due after a full ratio of modulator clocks, so data is settled.
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      cnt_r <= '0;
    end else if (mod_tick_o) begin
      cnt_r <= (cnt_r == osr_last) ? '0 : OSR_W'(cnt_r + 17'h00001);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o || done_o) begin
      cyc_r <= '0;
    end else begin
      cyc_r <= 21'(cyc_r + 21'h000001);
    end
  end

  AST_CONV_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> (cyc_r == 21'({osr_r, 4'h0} - 21'h000001)))
    else $error("Conversion length does not match the oversampling ratio.");

endmodule : arc_conv_timer

// >>> hdl/arc_ctrl.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module arc_ctrl
  import arc_pkg::*;
(
  // System
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [7:0] adr_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]     dat_o,
  output logic            ack_o,
  // Device control inputs
  input  wire logic       reset_cmd_i,
  input  wire logic       power_down_i,
  input  wire logic       conv_run_i,
  input  wire logic       ref_low0_i,
  input  wire logic       ref_low1_i,
  // Configuration outputs
  output arc_ref_cfg_t    ref_cfg_o,
  output arc_rate_cfg_t   rate_cfg_o,
  // Conversion timing and status
  output logic            conv_busy_o,
  output logic            mod_tick_o,
  output logic            conv_done_o,
  output logic [1:0]      ref_low_flags_o,
  output logic            irq_o
);

  logic [7:0]        data_rate_r;
  logic [7:0]        ref_ctrl_r;
  logic [IRQ_W-1:0]  irq_status_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_status_nxt;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [1:0]        low_seen_r;
  logic [1:0]        flags_r;
  logic [1:0]        flags_nxt;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic [31:0]       rd_mux;
  logic [5:0]        wb_idx;
  logic              wb_req;
  logic              wb_wr;
  logic              soft_rst;
  logic [1:0]        ref_pwr;

  // ---------------------------------------------------------------
  // Wishbone slave: one wait state, ack for one cycle per request.
  // ---------------------------------------------------------------
  assign wb_idx   = adr_i[7:2];
  assign wb_req   = cyc_i && stb_i && !ack_r;
  assign wb_wr    = wb_req && we_i && sel_i[0];
  assign soft_rst = rst_i || reset_cmd_i;
  assign ack_o    = ack_r;
  assign dat_o    = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_idx)
      IDX_DATA_RATE:  rd_mux[7:0] = data_rate_r;
      IDX_REF_CTRL:   rd_mux[7:0] = ref_ctrl_r;
      IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_r;
      IDX_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_r;
      IDX_MONITOR: begin
        rd_mux[MON_FLAG_LSB +: 2] = flags_r;
        rd_mux[MON_REFON]         = ref_cfg_o.int_ref_on;
        rd_mux[MON_EXTCLK]        = rate_cfg_o.ext_clk_sel;
        rd_mux[MON_BUSY]          = conv_busy_o;
      end
      default:        rd_mux = 32'h0;
    endcase
  end

  // Unmapped and write accesses read back zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0;
    end else if (wb_req) begin
      dat_r <= we_i ? 32'h0 : rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers. A reset command restores them exactly as
  // the reset input does, which also drops an external clock choice.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      data_rate_r <= DATA_RATE_RST;
    end else if (wb_wr && wb_idx == IDX_DATA_RATE) begin
      data_rate_r <= dat_i[7:0] & DATA_RATE_WM;
    end
  end

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ref_ctrl_r <= REF_CTRL_RST;
    end else if (wb_wr && wb_idx == IDX_REF_CTRL) begin
      ref_ctrl_r <= dat_i[7:0] & REF_CTRL_WM;
    end
  end

  // ---------------------------------------------------------------
  // Reference configuration.
  // ---------------------------------------------------------------
  assign ref_pwr = ref_ctrl_r[RC_PWR_LSB +: 2];

  always_comb begin
    ref_cfg_o.src        = arc_ref_decode(ref_ctrl_r[RC_SEL_LSB +: 2]);
    ref_cfg_o.int_ref_on = (ref_pwr == REFPWR_ON) ||
                           ((ref_pwr == REFPWR_AUTO) && !power_down_i);
    ref_cfg_o.pos_buf_en = !ref_ctrl_r[RC_PBUF_BIT];
    ref_cfg_o.neg_buf_en = !ref_ctrl_r[RC_NBUF_BIT];
  end

  // ---------------------------------------------------------------
  // Clock, filter and rate configuration.
  // ---------------------------------------------------------------
  always_comb begin
    rate_cfg_o.ext_clk_sel = data_rate_r[DR_CLK_BIT];
    rate_cfg_o.low_latency = !data_rate_r[DR_FILTER_BIT];
    rate_cfg_o.osr         = arc_osr_decode(data_rate_r[DR_RATE_LSB +: DR_RATE_W]);
  end

  arc_conv_timer u_timer (
    .clk_i      (clk_i),
    .rst_i      (soft_rst),
    .run_i      (conv_run_i),
    .osr_i      (rate_cfg_o.osr),
    .busy_o     (conv_busy_o),
    .mod_tick_o (mod_tick_o),
    .done_o     (conv_done_o)
  );

  // ---------------------------------------------------------------
  // Reference monitor: a low reference at any point of a conversion
  // is remembered and published in the flags when the result is due.
  // ---------------------------------------------------------------
  assign flags_nxt = low_seen_r | {ref_low1_i, ref_low0_i};

  always_ff @(posedge clk_i) begin
    if (soft_rst || conv_done_o || !conv_busy_o) begin
      low_seen_r <= 2'h0;
    end else begin
      low_seen_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      flags_r <= 2'h0;
    end else if (conv_done_o) begin
      flags_r <= flags_nxt;
    end
  end

  assign ref_low_flags_o = flags_r;

  // ---------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set beats clear.
  // ---------------------------------------------------------------
  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_CONV]  = conv_done_o;
    irq_set[IRQ_REFL0] = conv_done_o && flags_nxt[0];
    irq_set[IRQ_REFL1] = conv_done_o && flags_nxt[1];
    irq_clr            = (wb_wr && wb_idx == IDX_IRQ_STATUS) ? dat_i[IRQ_W-1:0] : '0;
    irq_status_nxt     = (irq_status_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= IRQ_RST;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= IRQ_RST;
    end else if (wb_wr && wb_idx == IDX_IRQ_MASK) begin
      irq_mask_r <= dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [4:0] tick_gap_r;
  logic       tick_seen_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || !conv_busy_o) begin
      tick_gap_r  <= 5'h00;
      tick_seen_r <= 1'b0;
    end else if (mod_tick_o) begin
      tick_gap_r  <= 5'h00;
      tick_seen_r <= 1'b1;
    end else begin
      tick_gap_r  <= 5'(tick_gap_r + 5'h01);
    end
  end

  sequence s_ref_write(int bit_pos);
    wb_wr && wb_idx == IDX_REF_CTRL && dat_i[bit_pos] && !reset_cmd_i;
  endsequence

  sequence s_rate_write(int bit_pos, logic val);
    wb_wr && wb_idx == IDX_DATA_RATE && dat_i[bit_pos] == val && !reset_cmd_i;
  endsequence

  sequence s_low_during_conv;
    conv_busy_o && ref_low0_i && !conv_done_o ##1 conv_busy_o[*1];
  endsequence

  sequence s_sel_write(logic [1:0] code);
    wb_wr && wb_idx == IDX_REF_CTRL && dat_i[RC_SEL_LSB +: 2] == code && !reset_cmd_i;
  endsequence

  AST_REF_RESET_DEFAULT: assert property ($past(rst_i) |->
    ref_cfg_o.src == ARC_REF_EXT0 && !ref_cfg_o.int_ref_on)
    else $error("Reference select not at external pair zero after reset.");

  AST_REF_INTERNAL: assert property (s_sel_write(REFSEL_INT) |=>
    ref_cfg_o.src == ARC_REF_INT)
    else $error("Internal reference routing does not follow select code 10.");

  AST_REF_AUTO_DOWN: assert property (
    (ref_pwr == REFPWR_AUTO) && power_down_i |-> !ref_cfg_o.int_ref_on)
    else $error("Internal reference stays on in power-down with auto mode.");

  AST_REF_ALWAYS_ON: assert property (
    (ref_pwr == REFPWR_ON) && power_down_i |-> ref_cfg_o.int_ref_on)
    else $error("Internal reference off while mode is always on.");

  AST_BUF_ACTIVE_LOW: assert property (
    s_ref_write(RC_PBUF_BIT) |=> !ref_cfg_o.pos_buf_en)
    else $error("Writing one to the positive buffer bit did not disable it.");

  AST_CLK_SELECT: assert property (
    s_rate_write(DR_CLK_BIT, 1'b1) |=> rate_cfg_o.ext_clk_sel)
    else $error("Clock select write did not choose the external clock.");

  AST_CLK_REVERT: assert property (
    reset_cmd_i |=> !rate_cfg_o.ext_clk_sel && ref_ctrl_r == REF_CTRL_RST)
    else $error("Reset command did not return the clock to the oscillator.");

  AST_MOD_DIVIDE: assert property (
    mod_tick_o && tick_seen_r |-> tick_gap_r == 5'(MOD_DIV_LAST))
    else $error("Modulator tick spacing is not sixteen system clocks.");

  AST_FILTER_LL: assert property (
    s_rate_write(DR_FILTER_BIT, 1'b0) |=> rate_cfg_o.low_latency)
    else $error("Filter bit zero did not select the low-latency filter.");

  AST_REF_FLAG: assert property (
    s_low_during_conv ##0 conv_done_o |=> ref_low_flags_o[0])
    else $error("Low reference during a conversion was not flagged.");

  AST_IRQ_SET_WINS: assert property (
    conv_done_o && irq_clr[IRQ_CONV] |=> irq_status_r[IRQ_CONV])
    else $error("Conversion event lost to a clear in the same cycle.");

  AST_REF_EXT1: assert property (s_sel_write(REFSEL_EXT1) |=>
    ref_cfg_o.src == ARC_REF_EXT1)
    else $error("Select code 01 did not choose external pair one.");

  // The reserved select code is the union of the two defined one-bit codes.
  AST_REF_RESERVED: assert property (s_sel_write(REFSEL_EXT1 | REFSEL_INT) |=>
    ref_cfg_o.src == ARC_REF_EXT0)
    else $error("Reserved select code did not fall back to external pair zero.");

  AST_REF_OFF_DEFAULT: assert property (
    ref_pwr == REFPWR_OFF |-> !ref_cfg_o.int_ref_on)
    else $error("Internal reference on while its power code is off.");

  AST_NBUF_ACTIVE_LOW: assert property (
    s_ref_write(RC_NBUF_BIT) |=> !ref_cfg_o.neg_buf_en)
    else $error("Writing one to the negative buffer bit did not disable it.");

  AST_BUF_ENABLE: assert property (
    wb_wr && wb_idx == IDX_REF_CTRL && !dat_i[RC_PBUF_BIT] && !reset_cmd_i |=>
    ref_cfg_o.pos_buf_en)
    else $error("Writing zero to the positive buffer bit did not enable it.");

  AST_CLK_INTERNAL: assert property (
    s_rate_write(DR_CLK_BIT, 1'b0) |=> !rate_cfg_o.ext_clk_sel)
    else $error("Clock select zero did not choose the internal oscillator.");

  AST_CLK_RESET: assert property ($past(rst_i) |->
    !rate_cfg_o.ext_clk_sel)
    else $error("Reset input did not return the clock to the oscillator.");

  AST_MOD_FIRST_TICK: assert property (
    $rose(conv_busy_o) |-> ##15 (mod_tick_o || !conv_busy_o))
    else $error("First modulator tick not sixteen clocks into the conversion.");

  AST_OSR_FILTER_FREE: assert property (
    $changed(rate_cfg_o.low_latency) && $stable(data_rate_r[DR_RATE_LSB +: DR_RATE_W]) |->
    $stable(rate_cfg_o.osr))
    else $error("Filter change altered the oversampling ratio.");

  AST_FILTER_OTHER: assert property (
    s_rate_write(DR_FILTER_BIT, 1'b1) |=> !rate_cfg_o.low_latency)
    else $error("Filter bit one still selects the low-latency filter.");

  AST_ACK_PULSE: assert property (
    ack_o |=> !ack_o)
    else $error("Bus acknowledge held for more than one cycle.");

  AST_CONV_IRQ: assert property (
    conv_done_o |=> irq_status_r[IRQ_CONV])
    else $error("Conversion result did not set its status bit.");

endmodule : arc_ctrl

// >>> verification/arc_host_model.sv
`timescale 1ns/10ps
module arc_host_model
  import arc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 16
)
(
  // System
  input  wire logic        clk_i,
  // Wishbone master
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // One classic cycle; the request stands until ack is sampled high.
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'h0};
    sel_o <= 4'hf;
    dat_o <= {24'h0, wd};
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
  endtask : xfer

  // The host waits SETTLE_CYCLES clocks for the internal reference to settle.
  task automatic settle;
    repeat (SETTLE_CYCLES) @(posedge clk_i);
  endtask : settle
endmodule : arc_host_model

// >>> verification/adc_ref_clock_rate_control_tb_top.sv
`timescale 1ns/10ps
module adc_ref_clock_rate_control_tb_top;
  import arc_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cyc, stb, we, ack;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   wdat, rdat;
  logic          reset_cmd_i = 1'b0;
  logic          power_down_i = 1'b0;
  logic          conv_run_i = 1'b0;
  logic          ref_low0_i = 1'b0;
  logic          ref_low1_i = 1'b0;
  arc_ref_cfg_t  ref_cfg;
  arc_rate_cfg_t rate_cfg;
  logic          busy, tick, done, irq;
  logic [1:0]    flags;
  int            num_errors = 0;
  int            n_compared = 0;
  int            cycles = 0;
  int            osr_tab [14] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264, 2560,
                                  1280, 640, 320, 256, 128, 64};

  always #4 clk_i = ~clk_i;

  arc_host_model i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
                         .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  arc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
                  .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
                  .reset_cmd_i(reset_cmd_i), .power_down_i(power_down_i),
                  .conv_run_i(conv_run_i), .ref_low0_i(ref_low0_i), .ref_low1_i(ref_low1_i),
                  .ref_cfg_o(ref_cfg), .rate_cfg_o(rate_cfg), .conv_busy_o(busy),
                  .mod_tick_o(tick), .conv_done_o(done), .ref_low_flags_o(flags),
                  .irq_o(irq));

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [31:0] d;
    i_host.xfer(1'b1, idx, v, d);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    i_host.xfer(1'b0, idx, 8'h00, d);
    chk(d, exp);
  endtask : rd

  task automatic t_reset;
    rd(IDX_DATA_RATE, 32'h14);
    rd(IDX_REF_CTRL, 32'h0);
    rd(6'h3f, 32'h0);
    chk(32'(ref_cfg), 32'({ARC_REF_EXT0, 1'b0, 1'b1, 1'b1}));
    chk(32'(rate_cfg), 32'({1'b0, 1'b0, 17'd12800}));
    $display("test reset done");
  endtask : t_reset

  task automatic t_ref;
    arc_ref_src_t s_exp;
    logic [7:0]   v;
    for (int pd = 0; pd < 2; pd++) begin
      power_down_i <= pd[0];
      for (int s = 0; s < 4; s++) begin
        for (int p = 0; p < 4; p++) begin
          // Internal reference selection goes with both buffers off.
          v = {2'h0, (s == 2) | p[0], (s == 2) | p[1], s[1:0], p[1:0]};
          wr(IDX_REF_CTRL, v);
          s_exp = (s == 2) ? ARC_REF_INT : (s == 1) ? ARC_REF_EXT1 : ARC_REF_EXT0;
          chk(32'(ref_cfg), 32'({s_exp, p == 2 || (p == 1 && pd == 0), !v[5], !v[4]}));
        end
      end
    end
    power_down_i <= 1'b0;
    $display("test reference done");
  endtask : t_ref

  task automatic t_rate;
    // Only the defined rate codes are written.
    for (int c = 0; c < 14; c++) begin
      for (int f = 0; f < 2; f++) begin
        wr(IDX_DATA_RATE, {1'b0, c[0], 1'b0, f[0], c[3:0]});
        chk(32'(rate_cfg), 32'({c[0], !f[0], osr_tab[c][16:0]}));
      end
    end
    wr(IDX_DATA_RATE, 8'h40);
    chk(32'(rate_cfg.ext_clk_sel), 32'h1);
    @(posedge clk_i);
    reset_cmd_i <= 1'b1;
    @(posedge clk_i);
    reset_cmd_i <= 1'b0;
    @(posedge clk_i);
    chk(32'(rate_cfg.ext_clk_sel), 32'h0);
    rd(IDX_DATA_RATE, 32'h14);
    $display("test rate done");
  endtask : t_rate

  task automatic t_conv;
    int cnt, ticks, n;
    cnt = 0;
    ticks = 0;
    n = 0;
    wr(IDX_DATA_RATE, 8'h1d);
    // Internal reference on and selected with both buffers off, then let it settle.
    wr(IDX_REF_CTRL, 8'h3a);
    i_host.settle();
    ref_low0_i <= 1'b1;
    ref_low1_i <= 1'b1;
    conv_run_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (busy === 1'b1) cnt++;
      if (tick === 1'b1) ticks++;
    end while (done !== 1'b1 && n < 5000);
    chk(cnt, 16 * 64);
    chk(ticks, 64);
    @(posedge clk_i);
    conv_run_i <= 1'b0;
    ref_low0_i <= 1'b0;
    ref_low1_i <= 1'b0;
    chk(32'(flags), 32'h3);
    rd(IDX_IRQ_STATUS, 32'h7);
    chk(32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 8'h02);
    chk(32'(irq), 32'h1);
    wr(IDX_IRQ_STATUS, 8'h02);
    chk(32'(irq), 32'h0);
    rd(IDX_IRQ_STATUS, 32'h5);
    rd(IDX_MONITOR, 32'h7);
    $display("test conversion done");
  endtask : t_conv

  // A status clear lands in the very cycle of the next result; the result must win.
  task automatic t_set_wins;
    int n;
    n = 0;
    wr(IDX_IRQ_STATUS, 8'h07);
    conv_run_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 5000);
    repeat (16 * 64 - 2) @(posedge clk_i);
    wr(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_IRQ_STATUS, 32'h1);
    rd(IDX_MONITOR, 32'h14);
    conv_run_i <= 1'b0;
    $display("test set wins done");
  endtask : t_set_wins

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ref();
    t_rate();
    t_conv();
    t_set_wins();
    close_out();
  end
endmodule : adc_ref_clock_rate_control_tb_top
